/* ars_register_service.sv */
// Contract
// - Addresses 0,1,2,5 select the four registers
// - Addressed service adds to normal pulse service
// - Addressed strobes gated by write/read time
// - Strobes reach all; only selected register acts
// - Low-address detect for addresses 0000 to 0007
// - Low-address detect suppresses erasable memory timing
// - Addresses above 0007 get no addressed service
// - Accumulator holds; loads on write pulse
// - Accumulator loads on address zero write
// - Accumulator write strobe makes a clear pulse only at clear time
// - Multiply shift pulse makes special accumulator strobe
// - Accumulator shift bits from lines plus two
// - Low-product shift bits from buffer and lines
// - Low-product holds product, remainder, double adds
// - Low-product bits 12,13 use accumulator strobe
// - Clear pulse only inside a write strobe
// - Reading never alters register contents
// - All read sources ORed onto write lines
module ars_register_service (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic write_time_i,
    input wire logic read_time_i,
    input wire logic clear_time_i,
    input wire logic addr_write_pulse_i,
    input wire logic addr_read_pulse_i,
    input wire logic [11:0] address_i,
    input wire ars_pkg::ars_sel_t write_pulse_i,
    input wire ars_pkg::ars_sel_t read_pulse_i,
    input wire ars_pkg::ars_mul_t mul_i,
    input wire logic [15:0] buffer_i,
    input wire logic [15:0] other_sources_i,
    output logic [15:0] write_lines_o,
    output logic low_address_detect_o,
    output logic erasable_inhibit_o,
    output ars_pkg::ars_sel_t write_strobe_o,
    output ars_pkg::ars_sel_t clear_pulse_o,
    output ars_pkg::ars_sel_t read_strobe_o,
    output logic acc_shift_write_strobe_o,
    output logic lowprod_shift_write_strobe_o,
    output ars_pkg::ars_regs_t regs_o
);

    function automatic logic addr_hit(input logic [11:0] addr, input logic [11:0] code,
                                      input logic detect);
        addr_hit = detect && (addr == code);
    endfunction : addr_hit

    ars_pkg::ars_regs_t regs_reg;
    ars_pkg::ars_regs_t regs_next;
    ars_pkg::ars_sel_t addr_sel;
    ars_pkg::ars_sel_t addr_wr;
    ars_pkg::ars_sel_t addr_rd;
    ars_pkg::ars_sel_t wr_strobe;
    ars_pkg::ars_sel_t rd_strobe;
    logic addr_write_strobe;
    logic addr_read_strobe;
    logic low_address_detect;
    logic address_zero_decode;
    logic shift_write_strobe;
    logic [15:0] read_or;
    logic [15:0] bus_w;
    logic [15:0] acc_shift_val;
    logic [15:0] lp_shift_val;

    assign addr_write_strobe = addr_write_pulse_i & write_time_i;
    assign addr_read_strobe = addr_read_pulse_i & read_time_i;

    assign low_address_detect = (address_i[11:ars_pkg::LOW_ADDR_BITS] ==
        ars_pkg::LOW_ADDR_TOP[11:ars_pkg::LOW_ADDR_BITS]);
    assign low_address_detect_o = low_address_detect;
    assign erasable_inhibit_o = low_address_detect;

    assign address_zero_decode = addr_hit(address_i, ars_pkg::ADDR_ACC, low_address_detect);
    assign addr_sel.acc = address_zero_decode;
    assign addr_sel.lowprod = addr_hit(address_i, ars_pkg::ADDR_LOWPROD, low_address_detect);
    assign addr_sel.link = addr_hit(address_i, ars_pkg::ADDR_LINK, low_address_detect);
    assign addr_sel.pc = addr_hit(address_i, ars_pkg::ADDR_PC, low_address_detect);

    assign addr_wr = addr_sel & {4{addr_write_strobe}};
    assign addr_rd = addr_sel & {4{addr_read_strobe}};

    assign wr_strobe = (write_pulse_i & {4{write_time_i}}) | addr_wr;
    assign rd_strobe = (read_pulse_i & {4{read_time_i}}) | addr_rd;
    assign write_strobe_o = wr_strobe;
    assign read_strobe_o = rd_strobe;

    assign clear_pulse_o = wr_strobe & {4{clear_time_i}};

    assign shift_write_strobe = mul_i.shift_accumulate_pulse & write_time_i &
        (mul_i.multiply_sub_one | mul_i.multiply_sub_three);
    assign acc_shift_write_strobe_o = shift_write_strobe;
    assign lowprod_shift_write_strobe_o = shift_write_strobe;

    assign read_or = ({16{rd_strobe.acc}} & regs_reg.acc) |
        ({16{rd_strobe.lowprod}} & regs_reg.lowprod) |
        ({16{rd_strobe.link}} & regs_reg.link) |
        ({16{rd_strobe.pc}} & regs_reg.pc);
    assign bus_w = read_or | other_sources_i;
    assign write_lines_o = bus_w;

    assign acc_shift_val = {buffer_i[ars_pkg::SIGN_BIT], buffer_i[ars_pkg::SIGN_BIT],
        bus_w[15:ars_pkg::ACC_SHIFT_OFS]};

    assign lp_shift_val = {buffer_i[ars_pkg::LP_BUF_SIGN], buffer_i[ars_pkg::LP_BUF_SIGN],
        bus_w[1:0], buffer_i[14:ars_pkg::LP_BUF_OFS]};

    // A plain write wins over a shift write in the same cycle
    // Registers change only on writes
    always_comb begin
        regs_next = regs_reg;
        if (wr_strobe.acc) begin
            regs_next.acc = bus_w;
        end else if (shift_write_strobe) begin
            regs_next.acc = acc_shift_val;
        end
        if (wr_strobe.lowprod) begin
            regs_next.lowprod = bus_w;
        end else if (shift_write_strobe) begin
            regs_next.lowprod = lp_shift_val;
        end
        if (wr_strobe.link) begin
            regs_next.link = bus_w;
        end
        if (wr_strobe.pc) begin
            regs_next.pc = bus_w;
        end
    end

    // Clear and reload merge into one edge
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            regs_reg <= {4{ars_pkg::REG_RST}};
        end else begin
            regs_reg <= regs_next;
        end
    end

    assign regs_o = regs_reg;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    sequence s_acc_wr;
        write_strobe_o.acc;
    endsequence

    sequence s_shift_only;
        shift_write_strobe && !write_strobe_o.acc && !write_strobe_o.lowprod;
    endsequence

    property p_acc_load;
        s_acc_wr |=> regs_o.acc == $past(write_lines_o);
    endproperty

    a_acc_load_value: assert property (p_acc_load)
        else $error("Accumulator did not load write lines");

    a_addr_zero_load: assert property (
        addr_write_pulse_i && write_time_i && address_i == 12'h000
        |=> regs_o.acc == $past(write_lines_o))
        else $error("Address zero write missed accumulator");

    a_shift_acc_bits: assert property (s_shift_only |=>
        regs_o.acc[13:0] == $past(write_lines_o[15:2]) &&
        regs_o.acc[15] == $past(buffer_i[15]) && regs_o.acc[14] == $past(buffer_i[15]))
        else $error("Shift write into accumulator wrong");

    a_shift_lp_bits: assert property (s_shift_only |=>
        regs_o.lowprod[11:0] == $past(buffer_i[14:3]) &&
        regs_o.lowprod[13:12] == $past(write_lines_o[1:0]) &&
        regs_o.lowprod[14] == $past(buffer_i[0]))
        else $error("Shift write into low product wrong");

    a_high_addr_block: assert property (address_i > 12'h007
        |-> !low_address_detect_o && addr_wr == 4'h0 && addr_rd == 4'h0)
        else $error("Addressed service above low window");

    a_mem_inhibit: assert property (address_i <= 12'h007 |-> erasable_inhibit_o)
        else $error("Memory timing not suppressed");

    a_one_selected: assert property (
        addr_write_pulse_i && write_time_i && address_i == 12'h005 && write_pulse_i == 4'h0
        |-> write_strobe_o == 4'h1)
        else $error("Wrong register selected");

    a_clear_in_write: assert property (clear_pulse_o != 4'h0
        |-> (clear_pulse_o & ~write_strobe_o) == 4'h0)
        else $error("Clear without write strobe");

    a_read_keeps: assert property (write_strobe_o == 4'h0 && !shift_write_strobe
        |=> $stable(regs_o))
        else $error("Register changed without write");

    a_bus_or: assert property (read_strobe_o.link
        |-> (write_lines_o & regs_o.link) == regs_o.link &&
        (write_lines_o & other_sources_i) == other_sources_i)
        else $error("Write lines not ORed");

    a_acc_clear: assert property (write_strobe_o.acc && clear_time_i
        |-> clear_pulse_o.acc)
        else $error("Accumulator clear pulse missing");

endmodule : ars_register_service

/* ars_pkg.sv */
package ars_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 16;

    // Program addresses of the addressable registers
    localparam logic [11:0] ADDR_ACC = 12'h000;
    localparam logic [11:0] ADDR_LOWPROD = 12'h001;
    localparam logic [11:0] ADDR_LINK = 12'h002;
    localparam logic [11:0] ADDR_PC = 12'h005;
    // Highest address of the low-address window (octal 0007)
    localparam logic [11:0] LOW_ADDR_TOP = 12'h007;
    localparam int LOW_ADDR_BITS = 3;

    localparam logic [15:0] REG_RST = 16'h0000;

    // Shift-accumulate field positions
    localparam int ACC_SHIFT_OFS = 2;
    localparam int ACC_SHIFT_TOP = 13;
    localparam int SIGN_BIT = 15;
    localparam int LP_BUF_OFS = 3;
    localparam int LP_BUF_TOP = 11;
    localparam int LP_BUS_LO = 12;
    localparam int LP_BUS_HI = 13;
    localparam int LP_BUF_SIGN = 0;

    // Timer figures
    localparam int CLK_PERIOD_NS = 100;
    localparam int CTRL_PULSE_NS = 750;
    localparam int WRITE_STROBE_NS = 500;
    localparam int CLEAR_PULSE_NS = 250;
    localparam int CLEAR_PULSE_CYC = (CLEAR_PULSE_NS / CLK_PERIOD_NS < 1) ? 1 :
        CLEAR_PULSE_NS / CLK_PERIOD_NS;

    typedef struct packed {
        logic acc;
        logic lowprod;
        logic link;
        logic pc;
    } ars_sel_t;

    typedef struct packed {
        logic [15:0] acc;
        logic [15:0] lowprod;
        logic [15:0] link;
        logic [15:0] pc;
    } ars_regs_t;

    typedef struct packed {
        logic shift_accumulate_pulse;
        logic multiply_sub_one;
        logic multiply_sub_three;
    } ars_mul_t;
endpackage : ars_pkg

/* ars_timer_model.sv */
module ars_timer_model (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [2:0] enable_i,
    output logic write_time_o,
    output logic read_time_o,
    output logic clear_time_o
);
    // Levels move only after an edge, never in the middle of a service window
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            {write_time_o, read_time_o, clear_time_o} <= 3'h0;
        end else begin
            {write_time_o, read_time_o, clear_time_o} <= enable_i;
        end
    end
endmodule : ars_timer_model

/* addressable_register_service_tb_top.sv */
module addressable_register_service_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic [11:0] addr;
        logic awp;
        ars_pkg::ars_sel_t wp;
        ars_pkg::ars_mul_t mul;
        logic [15:0] bufv;
        logic [15:0] oth;
        ars_pkg::ars_regs_t exp;
    } ars_row_t;
    logic clk_i = 1'h0;
    logic rst_n_i = 1'h0;
    logic [2:0] tmr_en = 3'h7;
    logic wt, rt, ct, lad, einh, asws, lsws;
    logic arp = 1'h0;
    logic [15:0] wl;
    ars_pkg::ars_sel_t rp = 4'h0;
    ars_pkg::ars_sel_t ws, cp, rs, esel;
    ars_pkg::ars_regs_t regs;
    ars_row_t idle = '{12'h009, 1'h0, 4'h0, 3'h0, 16'h0, 16'h1000, 64'h0};
    ars_row_t stim = '0;
    ars_row_t rows [9];
    int mismatches = 0;
    int tests_run = 0;
    int cycles = 0;

    always #50 clk_i = ~clk_i;

    ars_timer_model ars_timer_model_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .enable_i(tmr_en),
        .write_time_o(wt), .read_time_o(rt), .clear_time_o(ct));

    ars_register_service ars_register_service_i (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .write_time_i(wt), .read_time_i(rt), .clear_time_i(ct),
        .addr_write_pulse_i(stim.awp), .addr_read_pulse_i(arp), .address_i(stim.addr),
        .write_pulse_i(stim.wp), .read_pulse_i(rp), .mul_i(stim.mul), .buffer_i(stim.bufv),
        .other_sources_i(stim.oth), .write_lines_o(wl), .low_address_detect_o(lad),
        .erasable_inhibit_o(einh), .write_strobe_o(ws), .clear_pulse_o(cp),
        .read_strobe_o(rs), .acc_shift_write_strobe_o(asws),
        .lowprod_shift_write_strobe_o(lsws), .regs_o(regs));

    task automatic check(input logic [63:0] got, input logic [63:0] exp, input string msg);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : check

    task automatic rd(input logic [11:0] a, input logic ar, input logic [3:0] r,
        input logic [15:0] e);
        @(posedge clk_i);
        stim.addr <= a;
        arp <= ar;
        rp <= r;
        @(negedge clk_i);
        check(wl, e, "lines");
    endtask : rd

    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : summarize

    // Whole run is under 150 cycles; the ceiling leaves wide margin
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 2000) begin
            mismatches++;
            summarize();
        end
    end

    initial begin
        rows = '{
            '{12'h000, 1'h1, 4'h0, 3'h0, 16'h0, 16'h1234, 64'h1234_0000_0000_0000},
            '{12'h001, 1'h1, 4'h0, 3'h0, 16'h0, 16'h5678, 64'h1234_5678_0000_0000},
            '{12'h002, 1'h1, 4'h0, 3'h0, 16'h0, 16'h9ABC, 64'h1234_5678_9ABC_0000},
            '{12'h005, 1'h1, 4'h0, 3'h0, 16'h0, 16'h0DEF, 64'h1234_5678_9ABC_0DEF},
            '{12'h003, 1'h1, 4'h0, 3'h0, 16'h0, 16'hFFFF, 64'h1234_5678_9ABC_0DEF},
            '{12'h008, 1'h1, 4'h0, 3'h0, 16'h0, 16'hFFFF, 64'h1234_5678_9ABC_0DEF},
            '{12'h009, 1'h0, 4'h2, 3'h0, 16'h0, 16'hAAAA, 64'h1234_5678_AAAA_0DEF},
            '{12'h009, 1'h0, 4'h8, 3'h0, 16'h0, 16'h0F0F, 64'h0F0F_5678_AAAA_0DEF},
            '{12'h009, 1'h0, 4'h0, 3'h6, 16'h8009, 16'h0006, 64'hC001_E001_AAAA_0DEF}};
        repeat (12) @(posedge clk_i);
        rst_n_i <= 1'h1;
        @(negedge clk_i);
        check(regs, {4{ars_pkg::REG_RST}}, "reset");
        foreach (rows[i]) begin
            @(posedge clk_i);
            stim <= rows[i];
            esel = rows[i].wp | ({4{rows[i].awp}} & {rows[i].addr == ars_pkg::ADDR_ACC,
                rows[i].addr == ars_pkg::ADDR_LOWPROD, rows[i].addr == ars_pkg::ADDR_LINK,
                rows[i].addr == ars_pkg::ADDR_PC});
            @(negedge clk_i);
            check(lad, rows[i].addr <= ars_pkg::LOW_ADDR_TOP, "detect");
            check(einh, rows[i].addr <= ars_pkg::LOW_ADDR_TOP, "inhibit");
            // Shift strobe needs the pulse and one of the two multiply steps
            check(asws, rows[i].mul[2] & (rows[i].mul[1] | rows[i].mul[0]), "acc shift");
            check(lsws, rows[i].mul[2] & (rows[i].mul[1] | rows[i].mul[0]), "lp shift");
            if (rows[i].mul == 3'h0) begin
                check(ws, esel, "strobes");
                check(cp, esel, "clear");
            end
            @(posedge clk_i);
            stim <= idle;
            @(negedge clk_i);
            check(regs, rows[i].exp, "regs");
        end
        @(posedge clk_i);
        tmr_en <= 3'h3;
        repeat (2) @(posedge clk_i);
        stim <= '{12'h000, 1'h1, 4'h8, 3'h0, 16'h0, 16'hFFFF, 64'h0};
        @(negedge clk_i);
        check(ws, 4'h0, "no write time");
        check(cp, 4'h0, "no clear");
        @(posedge clk_i);
        stim <= idle;
        tmr_en <= 3'h7;
        @(negedge clk_i);
        check(regs.acc, 16'hC001, "acc held");
        repeat (2) @(posedge clk_i);
        rd(12'h009, 1'h0, 4'h8, 16'hD001);
        rd(12'h005, 1'h1, 4'h0, 16'h1DEF);
        rd(12'h001, 1'h1, 4'h2, 16'hFAAB);
        rd(12'h008, 1'h1, 4'h0, 16'h1000);
        @(posedge clk_i);
        arp <= 1'h0;
        rp <= 4'h0;
        @(negedge clk_i);
        check(regs, 64'hC001_E001_AAAA_0DEF, "read kept");
        // Third multiply step with all-zero lines and buffer
        @(posedge clk_i);
        stim <= '{12'h009, 1'h0, 4'h0, 3'h5, 16'h0, 16'h0, 64'h0};
        @(negedge clk_i);
        check(asws, 1'h1, "mp3 shift");
        @(posedge clk_i);
        stim <= idle;
        @(negedge clk_i);
        check(regs, 64'h0000_0000_AAAA_0DEF, "mp3 regs");
        @(posedge clk_i);
        rst_n_i <= 1'h0;
        @(negedge clk_i);
        check(regs, 64'h0, "mid reset");
        summarize();
    end
endmodule : addressable_register_service_tb_top
